// File: urt_cfg.svh
`ifndef URT_CFG_SVH
`define URT_CFG_SVH

// register byte offsets
`define URT_OFF_CTRL    8'h00
`define URT_OFF_BDIVI   8'h04
`define URT_OFF_BDIVF   8'h08
`define URT_OFF_TXHOLD  8'h0c
`define URT_OFF_RXDATA  8'h10
`define URT_OFF_ISTAT   8'h14
`define URT_OFF_IEN     8'h18
`define URT_OFF_ICLR    8'h1c

// control_reg_one fields
`define URT_CTRL_TX_ON  0
`define URT_CTRL_RX_ON  1
`define URT_CTRL_MODE_LO 2
`define URT_CTRL_STOP_LO 4
`define URT_CTRL_PAR_LO 6
`define URT_CTRL_RST    8'h00

// status / enable / clear bit positions
`define URT_ST_EMPTY    0
`define URT_ST_TDONE    1
`define URT_ST_BUSY     2
`define URT_ST_RDONE    3
`define URT_ST_PERR     4
`define URT_ST_FERR     5

// baud reset values
`define URT_BDIVI_RST   16'h0001
`define URT_BDIVF_RST   4'h0

// oversampling and stop lengths in sample ticks
`define URT_OVS         5'd16
`define URT_STOP_ONE    6'd16
`define URT_STOP_ONEHALF 6'd24
`define URT_STOP_TWO    6'd32
`define URT_SAMP_A      4'd7
`define URT_SAMP_B      4'd8
`define URT_SAMP_C      4'd9
`define URT_BIT_LAST    4'd15
`define URT_DATA_BITS   3'd7
`define URT_DED_INC     13'h1000
`define URT_STD_INC     13'h0010

`endif

// File: urt_pkg.sv
`default_nettype none
package urt_pkg;
	typedef enum logic [1:0] {MODE_X16 = 2'h0, MODE_X8 = 2'h1, MODE_X4 = 2'h2, MODE_DED = 2'h3} urt_mode_t;
	typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_CUSTOM = 2'h1, PAR_EVEN = 2'h2, PAR_ODD = 2'h3} urt_par_t;
	typedef enum logic [1:0] {STOP_1 = 2'h0, STOP_1H = 2'h1, STOP_2 = 2'h2, STOP_2B = 2'h3} urt_stop_t;

	typedef struct packed {
		logic      valid;
		logic [8:0] data;
		logic      perr;
		logic      ferr;
	} urt_rx_res_t;

	// parity bit for a byte in the chosen mode; custom uses the 9th data bit
	function automatic logic urt_par_bit(input logic [8:0] d, input urt_par_t m);
		logic p;
		p = ^d[7:0];
		unique case (m)
			PAR_EVEN: urt_par_bit = p;
			PAR_ODD: urt_par_bit = ~p;
			PAR_CUSTOM: urt_par_bit = d[8];
			PAR_NONE: urt_par_bit = 1'b0;
		endcase
	endfunction : urt_par_bit
endpackage : urt_pkg
`default_nettype wire

// File: urt_baud.sv
`timescale 1ns/100ps
`default_nettype none
`include "urt_cfg.svh"
module urt_baud (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire urt_pkg::urt_mode_t mode,
	input  wire logic [15:0]      div_int,
	input  wire logic [3:0]       div_frac,
	output var  logic             tick_r
);
	logic [21:0] acc_r;
	logic [21:0] acc_nxt;
	logic        tick_nxt;
	logic [21:0] div;
	logic [21:0] sum;

	// 16 ticks per bit: accumulate the tick weight, wrap on the divisor
	always_comb
	begin
		unique case (mode)
			urt_pkg::MODE_X16: div = {2'h0, div_int, 4'h0} + {18'h0, div_frac};
			urt_pkg::MODE_X8: div = {3'h0, div_int, 3'h0};
			urt_pkg::MODE_X4: div = {4'h0, div_int, 2'h0};
			urt_pkg::MODE_DED: div = {6'h0, div_int};
		endcase
		sum = acc_r + ((mode == urt_pkg::MODE_DED) ? {9'h0, `URT_DED_INC} : {9'h0, `URT_STD_INC});
		acc_nxt = sum;
		tick_nxt = 1'b0;
		if (div == 22'h0)
		begin
			acc_nxt = 22'h0;
		end
		else if (sum >= div)
		begin
			acc_nxt = sum - div;
			tick_nxt = 1'b1;
		end
		if (acc_nxt >= div)
		begin
			acc_nxt = 22'h0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			acc_r <= 22'h0;
			tick_r <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			tick_r <= tick_nxt;
		end
	end
endmodule : urt_baud
`default_nettype wire

// File: urt_rx.sv
`timescale 1ns/100ps
`default_nettype none
`include "urt_cfg.svh"
module urt_rx (
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              enable,
	input  wire logic              tick,
	input  wire logic              rxd,
	input  wire urt_pkg::urt_par_t par_mode,
	output var  urt_pkg::urt_rx_res_t res_r
);
	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA  = 5'b00100,
		RX_PAR   = 5'b01000,
		RX_STOP  = 5'b10000
	} urt_rx_st_t;

	urt_rx_st_t           st_r, st_nxt;
	logic [3:0]           cnt_r, cnt_nxt;
	logic [2:0]           bit_r, bit_nxt;
	logic [2:0]           smp_r, smp_nxt;
	logic [8:0]           shf_r, shf_nxt;
	logic                 prev_r;
	urt_pkg::urt_rx_res_t res_nxt;
	logic                 vote;
	logic                 bit_end;

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		bit_nxt = bit_r;
		smp_nxt = smp_r;
		shf_nxt = shf_r;
		res_nxt = res_r;
		res_nxt.valid = 1'b0;
		vote = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
		bit_end = tick && cnt_r == `URT_BIT_LAST;
		if (tick)
		begin
			cnt_nxt = cnt_r + 4'd1;
			if (cnt_r == `URT_SAMP_A || cnt_r == `URT_SAMP_B || cnt_r == `URT_SAMP_C)
			begin
				smp_nxt = {smp_r[1:0], rxd};
			end
		end
		if (!enable)
		begin
			st_nxt = RX_IDLE;
		end
		else
		begin
			unique case (st_r)
				RX_IDLE:
				begin
					cnt_nxt = 4'd0;
					if (prev_r && !rxd)
					begin
						st_nxt = RX_START;
					end
				end
				RX_START:
				if (bit_end)
				begin
					bit_nxt = 3'd0;
					st_nxt = vote ? RX_IDLE : RX_DATA;
				end
				RX_DATA:
				if (bit_end)
				begin
					shf_nxt = {1'b0, vote, shf_r[7:1]};
					bit_nxt = bit_r + 3'd1;
					if (bit_r == `URT_DATA_BITS)
					begin
						st_nxt = (par_mode == urt_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
					end
				end
				RX_PAR:
				if (bit_end)
				begin
					shf_nxt[8] = (par_mode == urt_pkg::PAR_CUSTOM) ? vote : 1'b0;
					res_nxt.perr = (par_mode != urt_pkg::PAR_CUSTOM) &&
						(vote != urt_pkg::urt_par_bit(shf_r, par_mode));
					st_nxt = RX_STOP;
				end
				RX_STOP:
				if (bit_end)
				begin
					res_nxt.valid = 1'b1;
					res_nxt.data = shf_r;
					res_nxt.ferr = !vote;
					if (par_mode == urt_pkg::PAR_NONE)
					begin
						res_nxt.perr = 1'b0;
					end
					st_nxt = RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			st_r <= RX_IDLE;
			cnt_r <= 4'd0;
			bit_r <= 3'd0;
			smp_r <= 3'h7;
			shf_r <= 9'h0;
			prev_r <= 1'b1;
			res_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			smp_r <= smp_nxt;
			shf_r <= shf_nxt;
			prev_r <= rxd;
			res_r <= res_nxt;
		end
	end
endmodule : urt_rx
`default_nettype wire

// File: urt_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "urt_cfg.svh"
module urt_top (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata_r,
	output var  logic        pready_r,
	output var  logic        pslverr_r,
	input  wire logic        rxd,
	output var  logic        txd_r,
	output var  logic [5:0]  irq_req_r
);
	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_PAR   = 5'b01000,
		TX_STOP  = 5'b10000
	} urt_tx_st_t;

	logic [7:0]           ctrl_r, ctrl_nxt;
	logic [15:0]          bdivi_r, bdivi_nxt;
	logic [3:0]           bdivf_r, bdivf_nxt;
	logic [8:0]           hold_r, hold_nxt;
	logic [8:0]           rdr_r, rdr_nxt;
	logic [5:0]           ien_r, ien_nxt;
	logic [5:0]           stat_r, stat_nxt;
	logic [31:0]          prdata_nxt;
	logic                 pready_nxt;
	logic                 pslverr_nxt;
	logic [5:0]           irq_nxt;
	logic                 acc;
	logic                 wr;
	logic                 mapped;
	logic                 tick;
	urt_pkg::urt_rx_res_t rx_res;
	urt_pkg::urt_par_t    par_mode;
	urt_pkg::urt_stop_t   stop_mode;
	urt_tx_st_t           tst_r, tst_nxt;
	logic [5:0]           tcnt_r, tcnt_nxt;
	logic [2:0]           tbit_r, tbit_nxt;
	logic [8:0]           tshf_r, tshf_nxt;
	logic                 txd_nxt;
	logic                 load;
	logic                 frame_done;
	logic [5:0]           stop_len;
	logic                 tx_en;

	assign par_mode = urt_pkg::urt_par_t'(ctrl_r[`URT_CTRL_PAR_LO +: 2]);
	assign stop_mode = urt_pkg::urt_stop_t'(ctrl_r[`URT_CTRL_STOP_LO +: 2]);
	assign tx_en = ctrl_r[`URT_CTRL_TX_ON];

	urt_baud urt_baud_inst (
		.clock    (clock),
		.reset_n  (reset_n),
		.mode     (urt_pkg::urt_mode_t'(ctrl_r[`URT_CTRL_MODE_LO +: 2])),
		.div_int  (bdivi_r),
		.div_frac (bdivf_r),
		.tick_r   (tick)
	);

	urt_rx urt_rx_inst (
		.clock    (clock),
		.reset_n  (reset_n),
		.enable   (ctrl_r[`URT_CTRL_RX_ON]),
		.tick     (tick),
		.rxd      (rxd),
		.par_mode (par_mode),
		.res_r    (rx_res)
	);

	// transmit shifter
	always_comb
	begin
		tst_nxt = tst_r;
		tcnt_nxt = tcnt_r;
		tbit_nxt = tbit_r;
		tshf_nxt = tshf_r;
		txd_nxt = 1'b1;
		load = 1'b0;
		frame_done = 1'b0;
		unique case (stop_mode)
			urt_pkg::STOP_1: stop_len = `URT_STOP_ONE;
			urt_pkg::STOP_1H: stop_len = `URT_STOP_ONEHALF;
			urt_pkg::STOP_2, urt_pkg::STOP_2B: stop_len = `URT_STOP_TWO;
		endcase
		if (tick)
		begin
			tcnt_nxt = tcnt_r + 6'd1;
		end
		unique case (tst_r)
			TX_IDLE:
			begin
				tcnt_nxt = 6'd0;
				if (tx_en && !stat_r[`URT_ST_EMPTY])
				begin
					load = 1'b1;
					tshf_nxt = hold_r;
					tst_nxt = TX_START;
				end
			end
			TX_START:
			begin
				txd_nxt = 1'b0;
				if (tick && tcnt_r == {1'b0, `URT_OVS} - 6'd1)
				begin
					tcnt_nxt = 6'd0;
					tbit_nxt = 3'd0;
					tst_nxt = TX_DATA;
				end
			end
			TX_DATA:
			begin
				txd_nxt = tshf_r[tbit_r];
				if (tick && tcnt_r == {1'b0, `URT_OVS} - 6'd1)
				begin
					tcnt_nxt = 6'd0;
					tbit_nxt = tbit_r + 3'd1;
					if (tbit_r == `URT_DATA_BITS)
					begin
						tst_nxt = (par_mode == urt_pkg::PAR_NONE) ? TX_STOP : TX_PAR;
					end
				end
			end
			TX_PAR:
			begin
				txd_nxt = urt_pkg::urt_par_bit(tshf_r, par_mode);
				if (tick && tcnt_r == {1'b0, `URT_OVS} - 6'd1)
				begin
					tcnt_nxt = 6'd0;
					tst_nxt = TX_STOP;
				end
			end
			TX_STOP:
			begin
				if (tick && tcnt_r == stop_len - 6'd1)
				begin
					frame_done = 1'b1;
					tst_nxt = TX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			tst_r <= TX_IDLE;
			tcnt_r <= 6'd0;
			tbit_r <= 3'd0;
			tshf_r <= 9'h0;
			txd_r <= 1'b1;
		end
		else
		begin
			tst_r <= tst_nxt;
			tcnt_r <= tcnt_nxt;
			tbit_r <= tbit_nxt;
			tshf_r <= tshf_nxt;
			txd_r <= txd_nxt;
		end
	end

	// bus slave, registers and flags
	always_comb
	begin
		acc = psel && penable && !pready_r;
		wr = psel && penable && pready_r && pwrite;
		mapped = paddr[1:0] == 2'h0 && paddr <= `URT_OFF_ICLR;
		ctrl_nxt = ctrl_r;
		bdivi_nxt = bdivi_r;
		bdivf_nxt = bdivf_r;
		hold_nxt = hold_r;
		rdr_nxt = rdr_r;
		ien_nxt = ien_r;
		stat_nxt = stat_r;
		pready_nxt = acc;
		pslverr_nxt = acc && !mapped;
		prdata_nxt = 32'h0;
		if (acc && !pwrite)
		begin
			unique case (paddr)
				`URT_OFF_CTRL: prdata_nxt = {24'h0, ctrl_r};
				`URT_OFF_BDIVI: prdata_nxt = {16'h0, bdivi_r};
				`URT_OFF_BDIVF: prdata_nxt = {28'h0, bdivf_r};
				`URT_OFF_TXHOLD: prdata_nxt = {23'h0, hold_r};
				`URT_OFF_RXDATA: prdata_nxt = {23'h0, rdr_r};
				`URT_OFF_ISTAT: prdata_nxt = {26'h0, stat_r};
				`URT_OFF_IEN: prdata_nxt = {26'h0, ien_r};
				default: prdata_nxt = 32'h0;
			endcase
		end
		// software clears first so a same-cycle hardware set wins
		if (wr)
		begin
			unique case (paddr)
				`URT_OFF_CTRL: ctrl_nxt = pwdata[7:0];
				`URT_OFF_BDIVI: bdivi_nxt = pwdata[15:0];
				`URT_OFF_BDIVF: bdivf_nxt = pwdata[3:0];
				`URT_OFF_IEN: ien_nxt = pwdata[5:0] & 6'h3b;
				`URT_OFF_ICLR:
				begin
					stat_nxt[`URT_ST_TDONE] = stat_r[`URT_ST_TDONE] & pwdata[`URT_ST_TDONE];
					stat_nxt[`URT_ST_RDONE] = stat_r[`URT_ST_RDONE] & pwdata[`URT_ST_RDONE];
					stat_nxt[`URT_ST_PERR] = stat_r[`URT_ST_PERR] & pwdata[`URT_ST_PERR];
					stat_nxt[`URT_ST_FERR] = stat_r[`URT_ST_FERR] & pwdata[`URT_ST_FERR];
				end
				default: ;
			endcase
		end
		if (load)
		begin
			stat_nxt[`URT_ST_EMPTY] = 1'b1;
		end
		if (wr && paddr == `URT_OFF_TXHOLD)
		begin
			hold_nxt = pwdata[8:0];
			stat_nxt[`URT_ST_EMPTY] = 1'b0;
		end
		if (frame_done)
		begin
			stat_nxt[`URT_ST_TDONE] = 1'b1;
		end
		stat_nxt[`URT_ST_BUSY] = (tst_nxt != TX_IDLE) || !stat_nxt[`URT_ST_EMPTY];
		if (rx_res.valid)
		begin
			rdr_nxt = rx_res.data;
			stat_nxt[`URT_ST_RDONE] = 1'b1;
			stat_nxt[`URT_ST_PERR] = stat_nxt[`URT_ST_PERR] | rx_res.perr;
			stat_nxt[`URT_ST_FERR] = stat_nxt[`URT_ST_FERR] | rx_res.ferr;
		end
		irq_nxt = stat_nxt & ien_nxt & 6'h3b;
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			ctrl_r <= `URT_CTRL_RST;
			bdivi_r <= `URT_BDIVI_RST;
			bdivf_r <= `URT_BDIVF_RST;
			hold_r <= 9'h0;
			rdr_r <= 9'h0;
			ien_r <= 6'h0;
			stat_r <= 6'h01;
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			irq_req_r <= 6'h0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			bdivi_r <= bdivi_nxt;
			bdivf_r <= bdivf_nxt;
			hold_r <= hold_nxt;
			rdr_r <= rdr_nxt;
			ien_r <= ien_nxt;
			stat_r <= stat_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_req_r <= irq_nxt;
		end
	end
endmodule : urt_top
`default_nettype wire

// File: urt_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module urt_top_checker (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata_r,
	input  wire logic        pready_r,
	input  wire logic        pslverr_r,
	input  wire logic        rxd,
	input  wire logic        txd_r,
	input  wire logic [5:0]  irq_req_r
);
	logic       wr, clr;
	logic [7:0] ctl_r, ctl_nxt;
	logic [5:0] ien_r, ien_nxt;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// shadow of control and enable writes
	always_comb
	begin
		wr = psel && penable && pready_r && pwrite;
		clr = wr && (paddr == 8'h1c || paddr == 8'h18);
		ctl_nxt = (wr && paddr == 8'h00) ? pwdata[7:0] : ctl_r;
		ien_nxt = (wr && paddr == 8'h18) ? pwdata[5:0] : ien_r;
	end
	always_ff @(posedge clock)
	begin
		ctl_r <= reset_n ? ctl_nxt : 8'h00;
		ien_r <= reset_n ? ien_nxt : 6'h00;
	end
	a_ready_wait: assert property ($rose(psel && penable) |=> pready_r)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (pready_r |=> !pready_r)
		else $error("ready longer than one cycle");
	a_err_map: assert property (pready_r |-> pslverr_r == (paddr > 8'h1c || paddr[1:0] != 2'h0))
		else $error("error response wrong for address");
	a_start_enable: assert property ($fell(txd_r) |-> ctl_r[0] || $past(ctl_r[0]))
		else $error("line driven low while transmit off");
	a_start_len: assert property ($fell(txd_r) |=> !txd_r [*8])
		else $error("start bit too short");
	a_tc_line: assert property ($rose(irq_req_r[1]) |-> txd_r)
		else $error("complete request before stop");
	a_irq_gate: assert property ((irq_req_r & ~(ien_r | $past(ien_r))) == 6'h00)
		else $error("request without its enable");
	a_busy_quiet: assert property (irq_req_r[2] == 1'b0)
		else $error("busy raised a request");
	a_flag_sticky: assert property (($past(irq_req_r) & ~irq_req_r & 6'h3a) != 6'h00 |-> clr || $past(clr))
		else $error("request dropped without clear");
	cover property (pready_r && pslverr_r);
	cover property ($rose(irq_req_r[3]));
	cover property ($fell(txd_r));
endmodule : urt_top_checker

bind urt_top urt_top_checker urt_top_checker_inst (.clock(clock), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
	.pready_r(pready_r), .pslverr_r(pslverr_r), .rxd(rxd), .txd_r(txd_r), .irq_req_r(irq_req_r));
`default_nettype wire

// File: urt_peer.sv
`timescale 1ns/100ps
`default_nettype none
module urt_peer #(
	parameter int BIT = 16
) (
	input  wire logic clock,
	input  wire logic txd,
	output var  logic rxd
);
	logic [7:0] got_q [$];
	logic [7:0] got;
	// frame bits lsb first, start bit in bit 0
	task automatic send(input logic [10:0] frame, input int len);
		for (int i = 0; i < len; i++)
		begin
			rxd <= frame[i];
			repeat (BIT) @(posedge clock);
		end
		rxd <= 1'b1;
	endtask : send
	task automatic pulse(input int n);
		rxd <= 1'b0;
		repeat (n) @(posedge clock);
		rxd <= 1'b1;
	endtask : pulse
	// sample mid-bit, keep each byte heard
	initial
	begin
		rxd = 1'b1;
		got = 8'h00;
		forever
		begin
			@(negedge txd);
			repeat (BIT / 2) @(posedge clock);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge clock);
				got[i] = txd;
			end
			got_q.push_back(got);
		end
	end
endmodule : urt_peer
`default_nettype wire

// File: urt_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module urt_top_tb;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic r;} urt_row_t;
	typedef struct packed {logic [7:0] d; logic p; logic s; logic [31:0] st;} urt_frm_t;
	logic        clock, reset_n, psel, penable, pwrite, pready_r, pslverr_r, rxd, txd_r, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata_r, rd;
	logic [5:0]  irq_req_r;
	int          errors, n_compared, cycles;
	urt_row_t    rows [13] = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h1, 1'b0},
		'{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h14, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h1c, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1},
		'{1'b0, 8'h06, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h18, 32'hff, 32'h0, 1'b0},
		'{1'b0, 8'h18, 32'h0, 32'h3b, 1'b0}, '{1'b1, 8'h14, 32'hff, 32'h0, 1'b0},
		'{1'b0, 8'h14, 32'h0, 32'h1, 1'b0}};
	urt_frm_t    frms [4] = '{'{8'h5a, 1'b0, 1'b1, 32'h09}, '{8'hc3, 1'b0, 1'b1, 32'h09},
		'{8'h01, 1'b0, 1'b1, 32'h19}, '{8'h02, 1'b1, 1'b0, 32'h39}};

	urt_top urt_top_inst (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
		.rxd(rxd), .txd_r(txd_r), .irq_req_r(irq_req_r));
	urt_peer #(.BIT(16)) urt_peer_inst (.clock(clock), .txd(txd_r), .rxd(rxd));

	task automatic complete_run();
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// one apb transfer, held until ready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready_r !== 1'b1 && n < 50);
		if (pready_r !== 1'b1)
			errors++;
		rd = prdata_r;
		er = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			complete_run();
		end
	end
	initial
	begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk(rd, rows[i].e);
			chk({31'h0, er}, {31'h0, rows[i].r});
		end
		apb(1'b1, 8'h0c, 32'h0a5);
		repeat (60) @(posedge clock);
		chk({31'h0, txd_r}, 32'h1);
		rdchk(8'h14, 32'h04);
		apb(1'b1, 8'h00, 32'h03);
		rdchk(8'h14, 32'h05);
		apb(1'b1, 8'h0c, 32'h03c);
		rdchk(8'h14, 32'h04);
		while (urt_peer_inst.got_q.size() < 2)
			@(posedge clock);
		repeat (40) @(posedge clock);
		rdchk(8'h14, 32'h03);
		chk({24'h0, urt_peer_inst.got_q[0]}, 32'ha5);
		chk({24'h0, urt_peer_inst.got_q[1]}, 32'h3c);
		chk({26'h0, irq_req_r}, 32'h03);
		apb(1'b1, 8'h1c, 32'hfffffffd);
		rdchk(8'h14, 32'h01);
		apb(1'b1, 8'h00, 32'h83);
		foreach (frms[i])
		begin
			urt_peer_inst.send({frms[i].s, frms[i].p, frms[i].d, 1'b0}, 11);
			repeat (4) @(posedge clock);
			apb(1'b0, 8'h10, 32'h0);
			chk({24'h0, rd[7:0]}, {24'h0, frms[i].d});
			rdchk(8'h14, frms[i].st);
		end
		chk({26'h0, irq_req_r}, 32'h39);
		apb(1'b1, 8'h18, 32'h0);
		chk({26'h0, irq_req_r}, 32'h0);
		apb(1'b1, 8'h1c, 32'hffffffc7);
		rdchk(8'h14, 32'h01);
		urt_peer_inst.pulse(4);
		repeat (200) @(posedge clock);
		rdchk(8'h14, 32'h01);
		apb(1'b1, 8'h00, 32'h81);
		urt_peer_inst.send({frms[0].s, frms[0].p, frms[0].d, 1'b0}, 11);
		repeat (4) @(posedge clock);
		rdchk(8'h14, 32'h01);
		apb(1'b1, 8'h04, 32'h36a);
		apb(1'b1, 8'h00, 32'hed);
		apb(1'b1, 8'h0c, 32'h081);
		while (urt_peer_inst.got_q.size() < 3)
			@(posedge clock);
		repeat (80) @(posedge clock);
		rdchk(8'h14, 32'h03);
		chk({24'h0, urt_peer_inst.got_q[2]}, 32'h81);
		apb(1'b1, 8'h00, 32'h02);
		apb(1'b1, 8'h18, 32'h3b);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rdchk(8'h00, 32'h0);
		rdchk(8'h04, 32'h1);
		rdchk(8'h14, 32'h01);
		chk({26'h0, irq_req_r}, 32'h0);
		complete_run();
	end
endmodule : urt_top_tb
`default_nettype wire
